// ---- shared/otn_mux_pkg.sv ----
package otn_mux_pkg;
    // Frame geometry, fixed for a two-instance OPUCn
    localparam int N_OPUC = 2;
    localparam int INST_W = 1;
    localparam int TS_PER_OPUC = 20;
    localparam int N_TS = N_OPUC * TS_PER_OPUC;
    localparam int TS_W = 6;
    // Payload structure identifier layout
    localparam logic [7:0] PT_MUX = 8'h16;
    localparam logic [7:0] PSI_PT_POS = 8'h00;
    localparam logic [7:0] MSI_FIRST = 8'h02;
    localparam logic [7:0] MSI_LAST = 8'h29;
    localparam int PORT_W = 14;
    localparam logic [PORT_W-1:0] PORT_MAX = 14'h0014;
    // Descriptor field positions (bit 1 is the byte's msb)
    localparam int DESC_FLAG_POS = 7;
    localparam int DESC_PORT_HI = 6;
    // Multiframe counters
    localparam logic [4:0] OMFI_MAX = 5'h13;
    localparam logic [7:0] MFAS_MAX = 8'hff;
    localparam logic [4:0] OMFI_RST = 5'h00;
    localparam logic [7:0] MFAS_RST = 8'h00;
    // Justification control
    localparam int CM_W = 10;
    localparam int SIG_W = 18;
    localparam int CN_W = 24;
    localparam int M_W = 13;
    localparam logic [2:0] JC_LAST = 3'h5;
    localparam int N_JC = 6;
    localparam logic [9:0] GRP_PER_MF = 10'h3b8;
    localparam logic [6:0] M_PER_TS = 7'h40;
    localparam int M_SHIFT = 1;
    localparam logic [5:0] CRC6_POLY = 6'h03;
    localparam logic [8:0] CRC9_POLY = 9'h011;
    // Link byte kinds
    localparam logic [1:0] KIND_PSI = 2'h0;
    localparam logic [1:0] KIND_OMFI = 2'h1;
    localparam logic [1:0] KIND_JC = 2'h2;

    // Msb-first serial CRC-6 over Cm, II and DI
    function automatic logic [5:0] crc6(input logic [11:0] d);
        logic [5:0] c;
        logic fb;
        c = 6'h00;
        for (int i = 11; i >= 0; i--) begin
            fb = c[5] ^ d[i];
            c = {c[4:0], 1'b0};
            if (fb) c = c ^ CRC6_POLY;
        end
        return c;
    endfunction : crc6

    // Msb-first serial CRC-9 over the 18-bit sigma CnD
    function automatic logic [8:0] crc9(input logic [17:0] d);
        logic [8:0] c;
        logic fb;
        c = 9'h000;
        for (int i = 17; i >= 0; i--) begin
            fb = c[8] ^ d[i];
            c = {c[7:0], 1'b0};
            if (fb) c = c ^ CRC9_POLY;
        end
        return c;
    endfunction : crc9

    // Tributary port numbers run from 1 to 10n
    function automatic logic port_ok(input logic [PORT_W-1:0] p);
        return (p != '0) && (p <= PORT_MAX);
    endfunction : port_ok
endpackage : otn_mux_pkg

// ---- shared/otn_oh_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// Overhead byte link between the mux source and the demux sink
interface otn_oh_if;
    logic frm; // Frame start pulse
    logic vld; // Byte valid
    logic [otn_mux_pkg::INST_W-1:0] inst; // OPUC instance, 0-based
    logic [1:0] kind; // PSI, OMFI or JC byte
    logic [7:0] idx; // PSI byte number or JC number
    logic [7:0] data; // Overhead byte
    modport src (output frm, output vld, output inst, output kind, output idx, output data);
    modport snk (input frm, input vld, input inst, input kind, input idx, input data);
endinterface : otn_oh_if
`default_nettype wire

// ---- src/otn_mux_oh_src.sv ----
// How it works
// - MSI is 40n bytes, two per slot
// - Descriptors go in PSI bytes 2..41
// - Descriptor bit 1 flags slot availability
// - Descriptor bit 9 flags slot occupation
// - Port number in bits 2-8, 10-16
// - Ports 1..10n only for allocated slots
// - Unallocated slot sends all-zero port
// - Reserved PSI bytes are sent as zero
// - Layout applies when payload type is 22
// - JC1-3 bits 3-8: Cm, II, DI, CRC-6
// - Sigma CnD, CRC-9, reserved in remaining bits
// - Block size m is 128 times slots
// - Timing granularity n is eight bits
// - Cm spreads client groups over payload groups
// - Sink computes Cn from Cm and sigma
// - Sink recovers from one bad sigma
// - OMFI byte sent in every instance
// - OMFI counts 0..19 in bits 4-8
// - Optional OMFI zero aligned with MFAS zero
// - Same OMFI in all instances; sink reads one
// - JC bytes sit in last slot's overhead
// - Stuff groups are driven to zero
`timescale 1ns/1ns
`default_nettype none
module otn_mux_oh_src (
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RSTN,
    // Frame timing
    input wire logic I_FRAME_STB,
    input wire logic I_ALIGN_MFAS,
    // Slot configuration
    input wire logic [otn_mux_pkg::N_TS-1:0] I_TS_AVAIL,
    input wire logic [otn_mux_pkg::N_TS-1:0] I_TS_ALLOC,
    input wire logic [otn_mux_pkg::N_TS-1:0][otn_mux_pkg::PORT_W-1:0] I_TS_PORT,
    // Tributary unit justification inputs
    input wire logic [otn_mux_pkg::INST_W-1:0] I_TU_LAST_A,
    input wire logic [4:0] I_TU_LAST_B,
    input wire logic [otn_mux_pkg::CM_W-1:0] I_CM,
    input wire logic I_II,
    input wire logic I_DI,
    input wire logic [otn_mux_pkg::SIG_W-1:0] I_SIGMA,
    // Payload group path
    input wire logic I_GRP_STB,
    input wire logic [127:0] I_GRP_WORD,
    // Status and payload outputs
    output logic [7:0] O_MFAS,
    output logic [4:0] O_OMFI,
    output logic O_GRP_VLD,
    output logic O_GRP_DATA,
    output logic [127:0] O_GRP_WORD,
    // Overhead link
    otn_oh_if.src LNK
);
    // One-hot burst sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_PSI = 4'h2,
        ST_OMFI = 4'h4,
        ST_JC = 4'h8
    } st_t;

    st_t st_r, st_nxt; // Sequencer state
    logic [otn_mux_pkg::INST_W-1:0] inst_r, inst_nxt; // Instance being sent
    logic [2:0] jcn_r, jcn_nxt; // JC byte number
    logic jc_frm_r, jc_frm_nxt; // This frame carries the JC bytes
    logic [7:0] mfas_r, mfas_nxt; // Frame alignment multiframe count
    logic [4:0] omfi_r, omfi_nxt; // OPU multiframe count
    logic [otn_mux_pkg::INST_W-1:0] last_a_r, last_a_nxt; // JC instance
    logic [otn_mux_pkg::CM_W-1:0] cm_r, cm_nxt; // Cm for JC bytes
    logic ii_r, ii_nxt;
    logic di_r, di_nxt;
    logic [otn_mux_pkg::SIG_W-1:0] sig_r, sig_nxt; // Sigma CnD for JC bytes
    logic [otn_mux_pkg::CM_W-1:0] cm_mf_r, cm_mf_nxt; // Cm steering payload
    logic [9:0] acc_r, acc_nxt; // Data/stuff accumulator
    logic frm_r, frm_nxt, vld_r, vld_nxt;
    logic [otn_mux_pkg::INST_W-1:0] linst_r, linst_nxt;
    logic [1:0] kind_r, kind_nxt;
    logic [7:0] idx_r, idx_nxt, data_r, data_nxt;
    logic gvld_r, gvld_nxt, gdata_r, gdata_nxt;
    logic [127:0] gword_r, gword_nxt;

    // Link and status outputs straight from flops
    assign LNK.frm = frm_r;
    assign LNK.vld = vld_r;
    assign LNK.inst = linst_r;
    assign LNK.kind = kind_r;
    assign LNK.idx = idx_r;
    assign LNK.data = data_r;
    assign O_MFAS = mfas_r;
    assign O_OMFI = omfi_r;
    assign O_GRP_VLD = gvld_r;
    assign O_GRP_DATA = gdata_r;
    assign O_GRP_WORD = gword_r;

    // Next-state logic for sequencer, counters and payload path
    always_comb begin
        logic [7:0] yoff;
        logic [otn_mux_pkg::TS_W-1:0] slot;
        logic occ;
        logic [otn_mux_pkg::PORT_W-1:0] port;
        logic [5:0] c6;
        logic [8:0] c9;
        logic [10:0] sum;
        logic adv;
        yoff = mfas_r - otn_mux_pkg::MSI_FIRST;
        slot = otn_mux_pkg::TS_W'(inst_r * otn_mux_pkg::TS_PER_OPUC)
            + otn_mux_pkg::TS_W'(yoff[7:1]);
        c6 = otn_mux_pkg::crc6({cm_r, ii_r, di_r});
        c9 = otn_mux_pkg::crc9(sig_r);
        sum = 11'h000;
        adv = 1'b0;
        occ = 1'b0;
        port = '0;
        st_nxt = st_r;
        inst_nxt = inst_r;
        jcn_nxt = jcn_r;
        jc_frm_nxt = jc_frm_r;
        mfas_nxt = mfas_r;
        omfi_nxt = omfi_r;
        last_a_nxt = last_a_r;
        cm_nxt = cm_r;
        ii_nxt = ii_r;
        di_nxt = di_r;
        sig_nxt = sig_r;
        cm_mf_nxt = cm_mf_r;
        acc_nxt = acc_r;
        frm_nxt = 1'b0;
        vld_nxt = 1'b0;
        linst_nxt = linst_r;
        kind_nxt = kind_r;
        idx_nxt = idx_r;
        data_nxt = 8'h00;
        gvld_nxt = 1'b0;
        gdata_nxt = gdata_r;
        gword_nxt = gword_r;
        unique case (st_r)
            ST_IDLE: begin
                if (I_FRAME_STB) begin
                    st_nxt = ST_PSI;
                    inst_nxt = '0;
                    frm_nxt = 1'b1;
                    // JC bytes ride in the overhead of the unit's last slot
                    jc_frm_nxt = (omfi_r == I_TU_LAST_B);
                    if (omfi_r == I_TU_LAST_B) begin
                        last_a_nxt = I_TU_LAST_A;
                        cm_nxt = I_CM;
                        ii_nxt = I_II;
                        di_nxt = I_DI;
                        sig_nxt = I_SIGMA;
                    end
                    // Payload follows the Cm taken at multiframe start
                    if (omfi_r == otn_mux_pkg::OMFI_RST) begin
                        cm_mf_nxt = I_CM;
                        acc_nxt = 10'h000;
                    end
                end
            end
            ST_PSI: begin
                vld_nxt = 1'b1;
                linst_nxt = inst_r;
                kind_nxt = otn_mux_pkg::KIND_PSI;
                idx_nxt = mfas_r;
                // Payload type only in instance 1; all other bytes default zero
                if (mfas_r == otn_mux_pkg::PSI_PT_POS && inst_r == '0) begin
                    data_nxt = otn_mux_pkg::PT_MUX;
                end else if (mfas_r >= otn_mux_pkg::MSI_FIRST
                             && mfas_r <= otn_mux_pkg::MSI_LAST) begin
                    // Occupied only with a legal port; else port is zeroed
                    occ = I_TS_ALLOC[slot] && otn_mux_pkg::port_ok(I_TS_PORT[slot]);
                    port = occ ? I_TS_PORT[slot] : '0;
                    if (!yoff[0]) begin
                        data_nxt = {I_TS_AVAIL[slot], port[13:7]};
                    end else begin
                        data_nxt = {occ, port[6:0]};
                    end
                end
                st_nxt = ST_OMFI;
            end
            ST_OMFI: begin
                // Same OMFI copied into every instance
                vld_nxt = 1'b1;
                linst_nxt = inst_r;
                kind_nxt = otn_mux_pkg::KIND_OMFI;
                idx_nxt = 8'h00;
                data_nxt = {3'h0, omfi_r};
                if (inst_r == otn_mux_pkg::INST_W'(otn_mux_pkg::N_OPUC - 1)) begin
                    if (jc_frm_r) begin
                        st_nxt = ST_JC;
                        jcn_nxt = 3'h0;
                    end else begin
                        st_nxt = ST_IDLE;
                        adv = 1'b1;
                    end
                end else begin
                    inst_nxt = inst_r + 1'b1;
                    st_nxt = ST_PSI;
                end
            end
            ST_JC: begin
                vld_nxt = 1'b1;
                linst_nxt = last_a_r;
                kind_nxt = otn_mux_pkg::KIND_JC;
                idx_nxt = {5'h00, jcn_r};
                // Bit 1 of JC4-6 is reserved and sent as zero
                unique case (jcn_r)
                    3'h0: data_nxt = {sig_r[17:16], cm_r[9:4]};
                    3'h1: data_nxt = {sig_r[15:14], cm_r[3:0], ii_r, di_r};
                    3'h2: data_nxt = {sig_r[13:12], c6};
                    3'h3: data_nxt = {1'b0, sig_r[11:5]};
                    3'h4: data_nxt = {1'b0, sig_r[4:0], c9[8:7]};
                    3'h5: data_nxt = {1'b0, c9[6:0]};
                    default: data_nxt = 8'h00;
                endcase
                if (jcn_r == otn_mux_pkg::JC_LAST) begin
                    st_nxt = ST_IDLE;
                    adv = 1'b1;
                end else begin
                    jcn_nxt = jcn_r + 3'h1;
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
        // Counters step once the frame's overhead burst is out
        if (adv) begin
            mfas_nxt = mfas_r + 8'h01;
            if (I_ALIGN_MFAS && mfas_r == otn_mux_pkg::MFAS_MAX) begin
                omfi_nxt = otn_mux_pkg::OMFI_RST;
            end else if (omfi_r == otn_mux_pkg::OMFI_MAX) begin
                omfi_nxt = otn_mux_pkg::OMFI_RST;
            end else begin
                omfi_nxt = omfi_r + 5'h01;
            end
        end
        // Sigma-delta spread of Cm data groups over the 952 groups
        if (I_GRP_STB) begin
            sum = {1'b0, acc_r} + {1'b0, cm_mf_r};
            gvld_nxt = 1'b1;
            if (sum >= {1'b0, otn_mux_pkg::GRP_PER_MF}) begin
                acc_nxt = 10'(sum - {1'b0, otn_mux_pkg::GRP_PER_MF});
                gdata_nxt = 1'b1;
                gword_nxt = I_GRP_WORD;
            end else begin
                acc_nxt = sum[9:0];
                gdata_nxt = 1'b0;
                gword_nxt = 128'h0;
            end
        end
    end

    // State registers, synchronous active-low reset
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RSTN) begin
            st_r <= ST_IDLE;
            inst_r <= '0;
            jcn_r <= 3'h0;
            jc_frm_r <= 1'b0;
            mfas_r <= otn_mux_pkg::MFAS_RST;
            omfi_r <= otn_mux_pkg::OMFI_RST;
            last_a_r <= '0;
            cm_r <= '0;
            ii_r <= 1'b0;
            di_r <= 1'b0;
            sig_r <= '0;
            cm_mf_r <= '0;
            acc_r <= 10'h000;
            frm_r <= 1'b0;
            vld_r <= 1'b0;
            linst_r <= '0;
            kind_r <= 2'h0;
            idx_r <= 8'h00;
            data_r <= 8'h00;
            gvld_r <= 1'b0;
            gdata_r <= 1'b0;
            gword_r <= 128'h0;
        end else begin
            st_r <= st_nxt;
            inst_r <= inst_nxt;
            jcn_r <= jcn_nxt;
            jc_frm_r <= jc_frm_nxt;
            mfas_r <= mfas_nxt;
            omfi_r <= omfi_nxt;
            last_a_r <= last_a_nxt;
            cm_r <= cm_nxt;
            ii_r <= ii_nxt;
            di_r <= di_nxt;
            sig_r <= sig_nxt;
            cm_mf_r <= cm_mf_nxt;
            acc_r <= acc_nxt;
            frm_r <= frm_nxt;
            vld_r <= vld_nxt;
            linst_r <= linst_nxt;
            kind_r <= kind_nxt;
            idx_r <= idx_nxt;
            data_r <= data_nxt;
            gvld_r <= gvld_nxt;
            gdata_r <= gdata_nxt;
            gword_r <= gword_nxt;
        end
    end
endmodule : otn_mux_oh_src
`default_nettype wire

// ---- src/otn_mux_oh_snk.sv ----
`timescale 1ns/1ns
`default_nettype none
module otn_mux_oh_snk (
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RSTN,
    // Slots used by the tributary unit
    input wire logic [5:0] I_TU_NTS,
    // Overhead link
    otn_oh_if.snk LNK,
    // Structure identifier
    output logic [7:0] O_PT,
    output logic O_PT_OK,
    output logic [otn_mux_pkg::N_TS-1:0] O_TS_AVAIL,
    output logic [otn_mux_pkg::N_TS-1:0] O_TS_ALLOC,
    output logic [otn_mux_pkg::N_TS-1:0][otn_mux_pkg::PORT_W-1:0] O_TS_PORT,
    output logic O_MSI_ERR,
    output logic [4:0] O_OMFI,
    // Justification results
    output logic [otn_mux_pkg::CM_W-1:0] O_CM,
    output logic O_II,
    output logic O_DI,
    output logic [otn_mux_pkg::SIG_W-1:0] O_SIGMA,
    output logic [otn_mux_pkg::CN_W-1:0] O_CN,
    output logic O_CN_VLD,
    output logic O_JC_ERR
);
    logic [7:0] msi_r [otn_mux_pkg::N_TS*2]; // Two descriptor bytes per slot
    logic [7:0] msi_nxt [otn_mux_pkg::N_TS*2];
    logic [7:0] jc_r [otn_mux_pkg::N_JC]; // JC1..JC6 of the current frame
    logic [7:0] jc_nxt [otn_mux_pkg::N_JC];
    logic [7:0] pt_r, pt_nxt;
    logic ptok_r, ptok_nxt;
    logic merr_r, merr_nxt;
    logic [4:0] omfi_r, omfi_nxt;
    logic eval_r, eval_nxt; // All six JC bytes are in
    logic [otn_mux_pkg::CM_W-1:0] cm_r, cm_nxt;
    logic ii_r, ii_nxt, di_r, di_nxt;
    logic [otn_mux_pkg::SIG_W-1:0] sig_r, sig_nxt; // Last good sigma CnD
    logic [otn_mux_pkg::CN_W-1:0] cn_r, cn_nxt;
    logic cnv_r, cnv_nxt, jerr_r, jerr_nxt;

    // Slot outputs taken from the stored descriptor flops
    for (genvar i = 0; i < otn_mux_pkg::N_TS; i++) begin : g_ts
        assign O_TS_AVAIL[i] = msi_r[2*i][otn_mux_pkg::DESC_FLAG_POS];
        assign O_TS_ALLOC[i] = msi_r[2*i+1][otn_mux_pkg::DESC_FLAG_POS];
        assign O_TS_PORT[i] = {msi_r[2*i][otn_mux_pkg::DESC_PORT_HI:0],
                               msi_r[2*i+1][otn_mux_pkg::DESC_PORT_HI:0]};
    end
    assign O_PT = pt_r;
    assign O_PT_OK = ptok_r;
    assign O_MSI_ERR = merr_r;
    assign O_OMFI = omfi_r;
    assign O_CM = cm_r;
    assign O_II = ii_r;
    assign O_DI = di_r;
    assign O_SIGMA = sig_r;
    assign O_CN = cn_r;
    assign O_CN_VLD = cnv_r;
    assign O_JC_ERR = jerr_r;

    // Next values: capture link bytes, check descriptors and JC fields
    always_comb begin
        logic [7:0] yoff;
        logic [otn_mux_pkg::TS_W-1:0] slot;
        logic [6:0] bi;
        logic [otn_mux_pkg::PORT_W-1:0] port;
        logic [11:0] cfld;
        logic [otn_mux_pkg::SIG_W-1:0] srx, diff;
        logic [8:0] c9rx;
        logic [otn_mux_pkg::M_W-1:0] m;
        logic [otn_mux_pkg::CN_W-1:0] mcm;
        yoff = LNK.idx - otn_mux_pkg::MSI_FIRST;
        slot = otn_mux_pkg::TS_W'(LNK.inst * otn_mux_pkg::TS_PER_OPUC)
            + otn_mux_pkg::TS_W'(yoff[7:1]);
        bi = {slot, 1'b0};
        port = {msi_r[bi][6:0], LNK.data[6:0]};
        cfld = {jc_r[0][5:0], jc_r[1][5:0]};
        srx = {jc_r[0][7:6], jc_r[1][7:6], jc_r[2][7:6], jc_r[3][6:0], jc_r[4][6:2]};
        c9rx = {jc_r[4][1:0], jc_r[5][6:0]};
        m = ({7'h00, I_TU_NTS} * {6'h00, otn_mux_pkg::M_PER_TS}) << otn_mux_pkg::M_SHIFT;
        mcm = '0;
        diff = '0;
        msi_nxt = msi_r;
        jc_nxt = jc_r;
        pt_nxt = pt_r;
        ptok_nxt = ptok_r;
        merr_nxt = 1'b0;
        omfi_nxt = omfi_r;
        eval_nxt = 1'b0;
        cm_nxt = cm_r;
        ii_nxt = ii_r;
        di_nxt = di_r;
        sig_nxt = sig_r;
        cn_nxt = cn_r;
        cnv_nxt = 1'b0;
        jerr_nxt = 1'b0;
        if (LNK.vld) begin
            unique case (LNK.kind)
                otn_mux_pkg::KIND_PSI: begin
                    if (LNK.idx == otn_mux_pkg::PSI_PT_POS && LNK.inst == '0) begin
                        pt_nxt = LNK.data;
                        ptok_nxt = (LNK.data == otn_mux_pkg::PT_MUX);
                    end else if (ptok_r && LNK.idx >= otn_mux_pkg::MSI_FIRST
                                 && LNK.idx <= otn_mux_pkg::MSI_LAST) begin
                        msi_nxt[{slot, yoff[0]}] = LNK.data;
                        // Second byte completes a descriptor: check its port
                        if (yoff[0]) begin
                            merr_nxt = LNK.data[7] ? !otn_mux_pkg::port_ok(port)
                                : (port != '0);
                        end
                    end
                end
                otn_mux_pkg::KIND_OMFI: begin
                    // Only instance 1 is processed; the copies are ignored
                    if (LNK.inst == '0) omfi_nxt = LNK.data[4:0];
                end
                otn_mux_pkg::KIND_JC: begin
                    if (LNK.idx[2:0] <= otn_mux_pkg::JC_LAST) begin
                        jc_nxt[LNK.idx[2:0]] = LNK.data;
                    end
                    eval_nxt = (LNK.idx[2:0] == otn_mux_pkg::JC_LAST);
                end
                default: ;
            endcase
        end
        // One cycle after JC6: check, keep good fields, form Cn
        if (eval_r) begin
            if (otn_mux_pkg::crc6(cfld) == jc_r[2][5:0]) begin
                cm_nxt = cfld[11:2];
                ii_nxt = cfld[1];
                di_nxt = cfld[0];
            end else begin
                jerr_nxt = 1'b1;
            end
            if (otn_mux_pkg::crc9(srx) == c9rx) begin
                sig_nxt = srx;
                diff = srx - sig_r;
            end else begin
                // Bad sigma: hold the last good one so the next frame recovers
                jerr_nxt = 1'b1;
            end
            mcm = {11'h000, m} * {14'h0000, cm_nxt};
            cn_nxt = mcm + {{(otn_mux_pkg::CN_W-otn_mux_pkg::SIG_W){diff[17]}}, diff};
            cnv_nxt = 1'b1;
        end
    end

    // State registers, synchronous active-low reset
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RSTN) begin
            for (int i = 0; i < otn_mux_pkg::N_TS*2; i++) msi_r[i] <= 8'h00;
            for (int i = 0; i < otn_mux_pkg::N_JC; i++) jc_r[i] <= 8'h00;
            pt_r <= 8'h00;
            ptok_r <= 1'b0;
            merr_r <= 1'b0;
            omfi_r <= otn_mux_pkg::OMFI_RST;
            eval_r <= 1'b0;
            cm_r <= '0;
            ii_r <= 1'b0;
            di_r <= 1'b0;
            sig_r <= '0;
            cn_r <= '0;
            cnv_r <= 1'b0;
            jerr_r <= 1'b0;
        end else begin
            msi_r <= msi_nxt;
            jc_r <= jc_nxt;
            pt_r <= pt_nxt;
            ptok_r <= ptok_nxt;
            merr_r <= merr_nxt;
            omfi_r <= omfi_nxt;
            eval_r <= eval_nxt;
            cm_r <= cm_nxt;
            ii_r <= ii_nxt;
            di_r <= di_nxt;
            sig_r <= sig_nxt;
            cn_r <= cn_nxt;
            cnv_r <= cnv_nxt;
            jerr_r <= jerr_nxt;
        end
    end
endmodule : otn_mux_oh_snk
`default_nettype wire

// ---- test/otn_mux_oh_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module otn_mux_oh_checker (
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RSTN,
    // Overhead link
    input wire logic frm,
    input wire logic vld,
    input wire logic [otn_mux_pkg::INST_W-1:0] inst,
    input wire logic [1:0] kind,
    input wire logic [7:0] idx,
    input wire logic [7:0] data
);
    default clocking @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RSTN);
    // Byte classes on the link
    wire logic psi = vld && kind == otn_mux_pkg::KIND_PSI;
    wire logic omf = vld && kind == otn_mux_pkg::KIND_OMFI;
    wire logic jc = vld && kind == otn_mux_pkg::KIND_JC;
    // Second descriptor byte: occupation flag and low port half
    wire logic dsc = psi && idx >= 8'h02 && idx <= 8'h29 && idx[0];
    // High port half of each instance's even byte, sent one frame earlier
    logic [6:0] hi_r [otn_mux_pkg::N_OPUC];
    always_ff @(posedge I_REF_CLK) begin
        if (psi && !idx[0]) hi_r[inst] <= data[6:0];
    end
    // A burst opens with instance 0 PSI, then its OMFI
    sequence lead_s;
        psi && inst == 1'h0 ##1 omf && inst == 1'h0;
    endsequence
    // The second and third justification bytes come as one unbroken run
    sequence jc_s;
        jc && idx == 8'h01 ##1 jc && idx == 8'h02;
    endsequence
    a_burst_order: assert property (frm |=> lead_s)
        else $error("burst order wrong");
    a_omfi_copy: assert property (omf && inst == 1'h0 |-> ##2 omf && data == $past(data, 2))
        else $error("omfi differs between instances");
    a_omfi_count: assert property (omf |-> data <= 8'h13)
        else $error("omfi out of range");
    a_res_zero: assert property (psi && (idx == 8'h01 || idx > 8'h29 ||
        inst != 1'h0 && idx == 8'h00) |-> data == 8'h00) else $error("reserved byte set");
    a_pt_code: assert property (psi && inst == 1'h0 && idx == 8'h00 |->
        data == otn_mux_pkg::PT_MUX) else $error("payload type wrong");
    a_free_slot: assert property (dsc && !data[7] |->
        data[6:0] == 7'h00 && hi_r[inst] == 7'h00) else $error("free slot port set");
    a_port_range: assert property (dsc && data[7] |->
        {hi_r[inst], data[6:0]} inside {[14'h0001:otn_mux_pkg::PORT_MAX]})
        else $error("port out of range");
    a_jc_spare: assert property (jc && idx >= 8'h03 |-> !data[7])
        else $error("reserved jc bit set");
    a_jc_run: assert property (jc && idx == 8'h00 |=> jc_s)
        else $error("jc run broken");
endmodule : otn_mux_oh_checker
`default_nettype wire

// ---- test/otn_mux_overhead_gmp_jc_omfi_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module otn_mux_overhead_gmp_jc_omfi_test;
    // Stimulus, all driven on the falling edge
    logic clk = 1'h0, rstn = 1'h0, stb = 1'h0, gs = 1'h0, ok;
    logic [39:0] av = 40'h0, al = 40'h0;
    logic [39:0][13:0] pt = '0;
    logic [9:0] cm = 10'h000;
    logic [17:0] sg = 18'h0, ps = 18'h0, so; // Sigma sent, previous good one, sink's copy
    logic [127:0] gw = {16{8'ha5}};
    // Observed outputs
    logic gv, gd, pok, cv, je;
    logic [127:0] go;
    logic [7:0] pto;
    logic [4:0] om;
    logic [39:0] ta, tl;
    logic [39:0][13:0] tp;
    logic [23:0] cn;
    int bad_count = 0, n_tests = 0, cyc = 0;
    // Slot, avail, alloc, port; port 21 is out of range and must be dropped
    int rows[4][4] = '{'{0, 1, 1, 5}, '{21, 1, 0, 7}, '{39, 0, 1, 20}, '{10, 1, 1, 21}};
    always #5 clk = ~clk;
    otn_oh_if lnk ();
    otn_mux_oh_src otn_mux_oh_src_i (.I_REF_CLK(clk), .I_RSTN(rstn), .I_FRAME_STB(stb),
        .I_ALIGN_MFAS(1'h1), .I_TS_AVAIL(av), .I_TS_ALLOC(al), .I_TS_PORT(pt),
        .I_TU_LAST_A(1'h1), .I_TU_LAST_B(5'h03), .I_CM(cm), .I_II(sg[0]), .I_DI(sg[1]),
        .I_SIGMA(sg), .I_GRP_STB(gs), .I_GRP_WORD(gw), .O_MFAS(), .O_OMFI(),
        .O_GRP_VLD(gv), .O_GRP_DATA(gd), .O_GRP_WORD(go), .LNK(lnk.src));
    otn_mux_oh_snk otn_mux_oh_snk_i (.I_REF_CLK(clk), .I_RSTN(rstn), .I_TU_NTS(6'h02),
        .LNK(lnk.snk), .O_PT(pto), .O_PT_OK(pok), .O_TS_AVAIL(ta), .O_TS_ALLOC(tl),
        .O_TS_PORT(tp), .O_MSI_ERR(), .O_OMFI(om), .O_CM(), .O_II(), .O_DI(), .O_SIGMA(so),
        .O_CN(cn), .O_CN_VLD(cv), .O_JC_ERR(je));
    otn_mux_oh_checker otn_mux_oh_checker_i (.I_REF_CLK(clk), .I_RSTN(rstn), .frm(lnk.frm),
        .vld(lnk.vld), .inst(lnk.inst), .kind(lnk.kind), .idx(lnk.idx), .data(lnk.data));
    // Count and report one comparison
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // One frame burst, then one payload group; Cm drops to 0 from frame 40
    task automatic frame(input int k);
        logic seen;
        logic [23:0] c;
        int f;
        seen = 1'h0;
        c = 24'h0;
        // Expected OMFI: plain count, forced to 0 when MFAS wraps
        f = k % 256 % 20;
        cm = k < 40 ? 10'h3b8 : 10'h000;
        sg = 18'(k * 5 + 1);
        stb = 1'h1;
        @(negedge clk) stb = 1'h0;
        // Cn pulse lands two cycles after the last JC byte
        repeat (13) begin
            @(negedge clk);
            if (cv === 1'h1) seen = 1'h1;
            if (cv === 1'h1) c = cn;
            chk("jc err", 0, je);
        end
        chk("omfi", f, om);
        chk("cn valid", f == 3, seen);
        if (f == 3) chk("cn", 24'(128 * 2 * cm + sg - ps), c);
        if (f == 3) ps = sg;
        chk("sigma", ps, so);
        gs = 1'h1;
        @(negedge clk) gs = 1'h0;
        chk("group", {k < 40, 1'h1}, {gd, gv});
        chk("word", 1, go === (k < 40 ? gw : 128'h0));
    endtask : frame
    // Print counts and verdict, then stop
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize
    // Hang guard, well above the roughly 3900 cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            summarize();
        end
    end
    initial begin
        foreach (rows[r]) begin
            av[rows[r][0]] = rows[r][1][0];
            al[rows[r][0]] = rows[r][2][0];
            pt[rows[r][0]] = rows[r][3][13:0];
        end
        repeat (8) @(negedge clk);
        rstn = 1'h1;
        // Frames 0..256 cover every descriptor byte and the aligned MFAS wrap
        for (int k = 0; k < 257; k++) frame(k);
        $display("frame test done");
        chk("pt", 9'h116, {pok, pto});
        foreach (rows[r]) begin
            ok = rows[r][2] == 1 && rows[r][3] inside {[1:20]};
            chk("avail", rows[r][1], ta[rows[r][0]]);
            chk("alloc", ok, tl[rows[r][0]]);
            chk("port", ok ? rows[r][3] : 0, tp[rows[r][0]]);
        end
        $display("slot test done");
        // Mid-run reset clears what the sink holds
        rstn = 1'h0;
        @(negedge clk) rstn = 1'h1;
        chk("reset", 0, {pok, pto, om});
        $display("reset test done");
        summarize();
    end
endmodule : otn_mux_overhead_gmp_jc_omfi_test
`default_nettype wire
